/* link_capture.sv */
// Pin synchroniser, link clock edge finder and link loss watch
`timescale 1ns/1ns
`default_nettype none
module link_capture #(
	parameter int LINKS = 4
) (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	// Link and strap pins
	input  wire logic [LINKS-1:0]       clock_pos,
	input  wire logic                   de_pin,
	input  wire logic [LINKS-1:0][23:0] main_pin,
	input  wire logic [LINKS-1:0][5:0]  extra_pin,
	input  wire logic [3:0]             strap_pin,
	// Toward the timing core
	link_capture_if.source              cap
);
	import quad_video_pkg::*;

	localparam int PW = 5 + LINKS * 30;
	localparam int CW = $clog2(LOSS_CYCLES + 1);

	logic [LINKS-1:0]       clk_s1;
	logic [LINKS-1:0]       clk_s2;
	logic [LINKS-1:0]       clk_s3;
	logic [PW-1:0]          pin_s1;
	logic [PW-1:0]          pin_s2;
	wire  [PW-1:0]          pins = {strap_pin, de_pin, extra_pin, main_pin};
	wire                    tick = clk_s2[0] & ~clk_s3[0];
	wire  [LINKS-1:0][29:0] grouped;

	// ==========================================================
	// Two stages on every pin; data and clock share latency
	always_ff @(posedge ref_clk) begin
		clk_s1 <= clock_pos;
		clk_s2 <= clk_s1;
		clk_s3 <= clk_s2;
		pin_s1 <= pins;
		pin_s2 <= pin_s1;
	end

	// ==========================================================
	// Word capture on the first link's rising edge
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cap.link_tick <= 1'b0;
			cap.de        <= 1'b0;
			cap.raw       <= '0;
			cap.straps    <= 4'h0;
		end else begin
			cap.link_tick <= tick;
			cap.straps    <= pin_s2[PW-1 -: 4];
			if (tick) begin
				cap.de  <= pin_s2[LINKS*30];
				cap.raw <= grouped;
			end
		end
	end

	// ==========================================================
	// Per link: regroup pairs and time out a silent clock
	for (genvar l = 0; l < LINKS; l++) begin : g_link
		logic [CW-1:0] idle;
		assign grouped[l] = {pin_s2[LINKS*24 + l*6 +: 6],
			pin_s2[l*24 +: 24]};
		always_ff @(posedge ref_clk) begin
			if (reset)
				idle <= CW'(LOSS_CYCLES);
			else if (clk_s2[l] != clk_s3[l])
				idle <= '0;
			else if (idle != CW'(LOSS_CYCLES))
				idle <= idle + 1'b1;
		end
		assign cap.alive[l] = idle != CW'(LOSS_CYCLES);
	end

	if (LINKS < 1) begin : g_bad_links
		$error("link_capture needs at least one link");
	end
endmodule
`default_nettype wire

/* link_capture_if.sv */
// Captured link words passed from the pin sampler to the timing core
`timescale 1ns/1ns
`default_nettype none
interface link_capture_if #(parameter int LINKS = 4);
	logic                   link_tick;
	logic [LINKS-1:0]       alive;
	logic                   de;
	logic [LINKS-1:0][29:0] raw;
	logic [3:0]             straps;
	modport source (output link_tick, alive, de, raw, straps);
	modport sink   (input  link_tick, alive, de, raw, straps);
endinterface
`default_nettype wire

/* quad_link_video_sink.sv */
// Quad link video sink: DE-only timing check, decode and fallback
// Overview of operation
// - Frame by data enable; syncs unused
// - No video: black or test pattern by strap
// - Pair E only for 10-bit; ignored otherwise
// - Local dimming enable input, unconnected when unused
// - Four links, each clock plus pairs A-E
// - Depth strap high selects 10-bit, low 8-bit
// - Mapping strap high JEIDA, low VESA
// - Each colour is 10-bit unsigned grey level
`timescale 1ns/1ns
`default_nettype none
module quad_link_video_sink #(
	parameter int LINKS = 4
) (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	// APB register port
	input  wire logic [7:0]             paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Deserialised links
	input  wire logic [LINKS-1:0]       link_clock_pos,
	input  wire logic                   link_de,
	input  wire logic [LINKS-1:0][23:0] link_main,
	input  wire logic [LINKS-1:0][5:0]  link_pair_e,
	// Straps
	input  wire logic                   depth_select,
	input  wire logic                   jeida_select,
	input  wire logic                   local_dim_enable,
	input  wire logic                   no_signal_mode,
	// Display side
	output logic [LINKS-1:0][29:0]      pixel_out,
	output logic                        pixel_valid,
	output logic                        local_dim_active,
	output logic                        signal_present
);
	import quad_video_pkg::*;

	function automatic logic [11:0] sat_inc(input logic [11:0] v);
		return (v == 12'hFFF) ? v : 12'(v + 12'h001);
	endfunction
	function automatic logic in_range(input logic [11:0] v,
		input int lo, input int hi);
		return (int'(v) >= lo) && (int'(v) <= hi);
	endfunction
	function automatic logic [9:0] map_colour(input logic [7:0] m,
		input logic [1:0] x, input logic ten, input logic jeida);
		if (!ten)
			return {m, 2'h0};
		return jeida ? {m, x} : {x, m};
	endfunction
	link_capture_if #(.LINKS(LINKS)) cap ();
	link_capture #(.LINKS(LINKS)) u_capture (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.clock_pos (link_clock_pos),
		.de_pin    (link_de),
		.main_pin  (link_main),
		.extra_pin (link_pair_e),
		.strap_pin ({no_signal_mode, local_dim_enable, jeida_select,
			depth_select}),
		.cap       (cap.source)
	);

	// ==========================================================
	// Line and frame measurement, DE edges only
	wire         tick    = cap.link_tick;
	wire         de      = cap.de;
	wire         depth10 = cap.straps[STRAP_DEPTH];
	wire         jeida   = cap.straps[STRAP_JEIDA];
	wire         pat_sel = cap.straps[STRAP_NOSIG];
	logic        de_prev;
	logic        locked;
	logic [11:0] h_cnt;
	logic [11:0] de_cnt;
	logic [11:0] gap_cnt;
	logic [11:0] line_pos;
	logic [11:0] gap_lines;
	logic [11:0] line_cnt;
	logic [11:0] h_last;
	logic [11:0] v_last;
	mode_t       mode;
	wire         rise      = tick & de & ~de_prev;
	wire         fall      = tick & ~de & de_prev;
	wire         frame_gap = gap_cnt > 12'(HBLANK_MAX);
	wire         line_chk  = locked & rise & ~frame_gap;
	wire         frame_chk = locked & rise & frame_gap;
	wire         pos_wrap  = (h_last != 12'h000) && (line_pos >= h_last);
	wire  [11:0] vblank    = 12'(gap_lines - 12'h001);
	wire  [11:0] vtotal    = 12'(line_cnt + vblank);
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			de_prev <= 1'b0;
			h_cnt   <= 12'h000;
			de_cnt  <= 12'h000;
			gap_cnt <= 12'h000;
		end else if (tick) begin
			de_prev <= de;
			h_cnt   <= rise ? 12'h001 : sat_inc(h_cnt);
			de_cnt  <= rise ? 12'h001 : (de ? sat_inc(de_cnt) : de_cnt);
			gap_cnt <= fall ? 12'h001 : (de ? 12'h000 : sat_inc(gap_cnt));
		end
	end
	// Blank lines are counted against the last measured line length
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			line_pos  <= 12'h000;
			gap_lines <= 12'h000;
			line_cnt  <= 12'h000;
			h_last    <= 12'h000;
		end else if (tick) begin
			line_pos  <= (rise | pos_wrap) ? 12'h001 : sat_inc(line_pos);
			gap_lines <= rise ? 12'h000
				: (pos_wrap ? sat_inc(gap_lines) : gap_lines);
			if (rise)
				line_cnt <= frame_gap ? 12'h001 : sat_inc(line_cnt);
			if (rise & ~frame_gap)
				h_last <= h_cnt;
		end
	end
	// Checks start only after a whole frame gap has been seen
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			locked <= 1'b0;
			v_last <= 12'h000;
		end else begin
			if (!signal_present)
				locked <= 1'b0;
			else if (rise & frame_gap)
				locked <= 1'b1;
			if (frame_chk)
				v_last <= vtotal;
		end
	end
	wire [ERR_W-1:0] err_set;
	assign err_set[ERR_ACTIVE] = locked & fall
		& (de_cnt != 12'(H_ACTIVE));
	assign err_set[ERR_HBLANK] = line_chk
		& ~in_range(gap_cnt, HBLANK_MIN, HBLANK_MAX);
	assign err_set[ERR_HTOTAL] = line_chk
		& ~in_range(h_cnt, HTOTAL_MIN, HTOTAL_MAX);
	assign err_set[ERR_LINES]  = frame_chk
		& (line_cnt != 12'(V_ACTIVE));
	assign err_set[ERR_VBLANK] = frame_chk
		& ~(in_range(vblank, VBLANK_MIN, VBLANK_MAX)
		| in_range(vblank, VBLANK2_MIN, VBLANK2_MAX));
	assign err_set[ERR_VTOTAL] = frame_chk
		& ~(in_range(vtotal, VTOTAL_MIN, VTOTAL_MAX)
		| in_range(vtotal, VTOTAL2_MIN, VTOTAL2_MAX));

	// ==========================================================
	// APB slave, zero wait states
	logic [1:0]       ctrl;
	logic [ERR_W-1:0] errors;
	wire              setup  = psel & ~penable;
	wire              wr     = psel & penable & pready & pwrite;
	wire              mapped = (paddr == CTRL_ADDR)
		| (paddr == STATUS_ADDR) | (paddr == ERRORS_ADDR)
		| (paddr == MEASURE_ADDR);
	wire [ERR_W-1:0]  err_clr = (wr && paddr == ERRORS_ADDR)
		? pwdata[ERR_W-1:0] : '0;
	wire [31:0]       status_word = 32'({cap.alive, cap.straps, locked,
		mode == MODE_LIVE});
	wire [31:0]       rd_mux =
		(paddr == CTRL_ADDR)    ? {30'h0, ctrl} :
		(paddr == STATUS_ADDR)  ? status_word :
		(paddr == ERRORS_ADDR)  ? 32'(errors) :
		(paddr == MEASURE_ADDR) ? {4'h0, v_last, 4'h0, h_last} : 32'h0;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			ctrl    <= CTRL_RESET;
			errors  <= '0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= setup ? rd_mux : 32'h0;
			if (wr && paddr == CTRL_ADDR)
				ctrl <= pwdata[1:0];
			// A new event wins over a clear in the same cycle
			errors <= (errors & ~err_clr) | err_set;
		end
	end

	// ==========================================================
	// Pixel path and fallback display
	logic  [11:0]           fb_h;
	wire                    live_ok = (&cap.alive) & ctrl[CTRL_ENABLE]
		& ~ctrl[CTRL_FORCE];
	wire                    fb_active = fb_h < 12'(H_ACTIVE);
	wire   [2:0]            bar = ~fb_h[8:6];
	wire   [29:0]           bar_pix = {{10{bar[2]}}, {10{bar[1]}},
		{10{bar[0]}}};
	wire   [LINKS-1:0][29:0] pattern = {LINKS{bar_pix}};
	wire   [LINKS-1:0][29:0] decoded;
	for (genvar l = 0; l < LINKS; l++) begin : g_dec
		for (genvar c = 0; c < 3; c++) begin : g_col
			assign decoded[l][c*10 +: 10] = map_colour(
				cap.raw[l][c*8 +: 8], cap.raw[l][24 + c*2 +: 2],
				depth10, jeida);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mode             <= MODE_FALLBACK;
			fb_h             <= 12'h000;
			signal_present   <= 1'b0;
			local_dim_active <= 1'b0;
		end else begin
			mode             <= live_ok ? MODE_LIVE : MODE_FALLBACK;
			fb_h             <= (fb_h == 12'(FB_H_TOTAL - 1)) ? 12'h000
				: 12'(fb_h + 12'h001);
			signal_present   <= &cap.alive;
			local_dim_active <= cap.straps[STRAP_DIM];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pixel_out   <= '0;
			pixel_valid <= 1'b0;
		end else begin
			unique case (mode)
				MODE_LIVE: begin
					pixel_valid <= tick & de;
					if (tick)
						pixel_out <= decoded;
				end
				MODE_FALLBACK: begin
					pixel_valid <= fb_active;
					pixel_out   <= pat_sel ? pattern : '0;
				end
			endcase
		end
	end

	if (LINKS != 4) begin : g_bad_links
		$error("quad_link_video_sink serves exactly four links");
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	de_only_a: assert property ((mode == MODE_LIVE && tick) |=>
		pixel_valid == $past(de)) else $error("valid not from enable");
	black_fill_a: assert property ((mode == MODE_FALLBACK &&
		!pat_sel) |=> pixel_out == '0) else $error("fallback not black");
	pattern_fill_a: assert property ((mode == MODE_FALLBACK &&
		pat_sel) |=> pixel_out == $past(pattern) &&
		pixel_valid == $past(fb_active)) else $error("pattern wrong");
	depth8_pad_a: assert property ((mode == MODE_LIVE && tick &&
		!depth10) |=> pixel_out[0][1:0] == 2'h0 &&
		pixel_out[0][21:20] == 2'h0) else $error("8-bit not padded");
	dim_follow_a: assert property ($changed(cap.straps[STRAP_DIM])
		|=> local_dim_active == $past(cap.straps[STRAP_DIM]))
		else $error("dimming strap lost");
	link_loss_a: assert property (!(&cap.alive) |=>
		!signal_present && mode == MODE_FALLBACK)
		else $error("dead link still live");
	jeida_map_a: assert property ((mode == MODE_LIVE && tick &&
		depth10 && jeida) |=> pixel_out[0][1:0] ==
		$past(cap.raw[0][25:24])) else $error("JEIDA low bits wrong");
	vesa_map_a: assert property ((mode == MODE_LIVE && tick &&
		depth10 && !jeida) |=> pixel_out[0][9:8] ==
		$past(cap.raw[0][25:24])) else $error("VESA high bits wrong");
	grey_black_a: assert property ((mode == MODE_LIVE && tick &&
		cap.raw[0] == 30'h0) |=> pixel_out[0] == 30'h0)
		else $error("zero input not black");
	apb_ready_a: assert property (setup |=> pready ##1 !pready)
		else $error("ready not one cycle");
endmodule
`default_nettype wire

/* quad_link_video_sink_tb.sv */
// Self-checking bench for the quad link video sink
`timescale 1ns/1ns
`default_nettype none
module quad_link_video_sink_tb;
	import quad_video_pkg::*;

	logic             ref_clk;
	logic             reset;
	logic [7:0]       paddr;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic [3:0]       clock_pos;
	logic             de;
	logic [3:0][23:0] main;
	logic [3:0][5:0]  pair_e;
	logic             depth_select;
	logic             jeida_select;
	logic             local_dim_enable;
	logic             no_signal_mode;
	logic [3:0][29:0] pixel_out;
	logic             pixel_valid;
	logic             local_dim_active;
	logic             signal_present;
	logic [31:0]      rd;
	logic             er;
	logic [29:0]      px;
	logic [9:0]       st;
	int               fail_count;
	int               n_tests;
	int               cycles;
	int               h;
	int               nz;

	quad_link_video_sink #(.LINKS(4)) quad_link_video_sink_i (
		.ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_clock_pos(clock_pos), .link_de(de), .link_main(main),
		.link_pair_e(pair_e), .depth_select(depth_select),
		.jeida_select(jeida_select), .local_dim_enable(local_dim_enable),
		.no_signal_mode(no_signal_mode), .pixel_out(pixel_out),
		.pixel_valid(pixel_valid), .local_dim_active(local_dim_active),
		.signal_present(signal_present)
	);

	video_source_model video_source_model_i (
		.clock_pos(clock_pos), .de(de), .main(main), .pair_e(pair_e)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Shared tasks
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic grab();
		int t;
		t = 0;
		while (pixel_valid !== 1'b1 && t < 2000) begin
			@(posedge ref_clk);
			t++;
		end
	endtask

	// Whole run is near 77000 cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 90000) begin
			fail_count++;
			end_sim();
		end
	end

	// ==========================================================
	// Tests
	initial begin
		reset = 1'b1;
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		depth_select = 1'b1;
		jeida_select = 1'b0;
		local_dim_enable = 1'b0;
		no_signal_mode = 1'b0;
		fail_count = 0;
		n_tests = 0;
		cycles = 0;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;

		apb(1'b0, CTRL_ADDR, 32'h0);
		check("ctrl", rd, 32'h1);
		check("ctrl slverr", {31'h0, er}, 32'h0);
		apb(1'b0, ERRORS_ADDR, 32'h0);
		check("errors", rd, 32'h0);
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		check("write slverr", {31'h0, er}, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		check("read unmapped", {er, rd[30:0]}, 32'h80000000);
		check("present", signal_present, 1'b0);
		$display("test registers done");

		for (int ns = 0; ns < 2; ns++) begin
			no_signal_mode <= ns[0];
			repeat (8) @(posedge ref_clk);
			h = 0;
			nz = 0;
			repeat (550) begin
				@(posedge ref_clk);
				h += (pixel_valid === 1'b1);
				if (pixel_valid === 1'b1 && pixel_out !== '0)
					nz = 1;
			end
			check("fallback valid", h, 480);
			check("fallback data", nz, ns);
		end
		$display("test no video done");

		for (int m = 0; m < 4; m++) begin
			depth_select <= m[1];
			jeida_select <= m[0];
			local_dim_enable <= m[0] ^ m[1];
			video_source_model_i.ten = m[1];
			st = {4'hF, 1'b1, m[0] ^ m[1], m[0], m[1], 2'h1};
			px = !m[1] ? {8'hA5, 2'h0, 8'h3C, 2'h0, 8'h0F, 2'h0}
				: m[0] ? {8'hA5, 2'h2, 8'h3C, 2'h1, 8'h0F, 2'h3}
				: {2'h2, 8'hA5, 2'h1, 8'h3C, 2'h3, 8'h0F};
			fork
				video_source_model_i.run(250, 2, 480, 70);
				begin
					repeat (2400) @(posedge ref_clk);
					apb(1'b0, STATUS_ADDR, 32'h0);
					check("status", rd & 32'h3FD, {22'h0, st});
					grab();
					check("valid seen", pixel_valid, 1'b1);
					for (int k = 0; k < 4; k++)
						check("pixel", pixel_out[k], px);
					check("dim", local_dim_active, m[0] ^ m[1]);
				end
			join
			apb(1'b0, MEASURE_ADDR, 32'h0);
			check("line total", rd & 32'hFFF, 32'd550);
			$display("test decode mode %0d done", m);
		end

		apb(1'b1, ERRORS_ADDR, 32'h3F);
		apb(1'b0, ERRORS_ADDR, 32'h0);
		check("errors cleared", rd, 32'h0);
		video_source_model_i.run(250, 1, 479, 70);
		video_source_model_i.run(0, 1, 480, 30);
		video_source_model_i.run(0, 2, 480, 70);
		video_source_model_i.run(250, 1, 480, 70);
		apb(1'b0, ERRORS_ADDR, 32'h0);
		check("errors set", rd & 32'hF, 32'hF);
		apb(1'b1, ERRORS_ADDR, 32'h3F);
		apb(1'b0, ERRORS_ADDR, 32'h0);
		check("errors w1c", rd, 32'h0);
		$display("test timing errors done");

		fork
			video_source_model_i.run(250, 1, 480, 70);
			begin
				repeat (2400) @(posedge ref_clk);
				apb(1'b1, CTRL_ADDR, 32'h0);
				apb(1'b0, STATUS_ADDR, 32'h0);
				check("disabled", rd & 32'h1, 32'h0);
				apb(1'b1, CTRL_ADDR, 32'h1);
				apb(1'b0, STATUS_ADDR, 32'h0);
				check("enabled", rd & 32'h1, 32'h1);
				apb(1'b1, CTRL_ADDR, 32'h3);
				apb(1'b0, CTRL_ADDR, 32'h0);
				check("ctrl readback", rd, 32'h3);
				apb(1'b0, STATUS_ADDR, 32'h0);
				check("forced", rd & 32'h1, 32'h0);
			end
		join
		repeat (300) @(posedge ref_clk);
		check("lost", signal_present, 1'b0);
		$display("test fallback done");
		end_sim();
	end
endmodule
`default_nettype wire

/* quad_video_pkg.sv */
// Shared constants and types for the quad link video sink
package quad_video_pkg;

	// ==========================================================
	// Line and frame timing, in link clocks and lines; FB_H_TOTAL in reference clocks
	localparam int H_ACTIVE    = 480;
	localparam int HBLANK_MIN  = 40;
	localparam int HBLANK_MAX  = 200;
	localparam int HTOTAL_MIN  = 520;
	localparam int HTOTAL_MAX  = 680;
	localparam int V_ACTIVE    = 1080;
	localparam int VBLANK_MIN  = 20;
	localparam int VBLANK_MAX  = 86;
	localparam int VBLANK2_MIN = 228;
	localparam int VBLANK2_MAX = 300;
	localparam int VTOTAL_MIN  = 1100;
	localparam int VTOTAL_MAX  = 1166;
	localparam int VTOTAL2_MIN = 1308;
	localparam int VTOTAL2_MAX = 1380;
	localparam int FB_H_TOTAL  = 550;

	// ==========================================================
	// Link loss detection
	localparam int CLK_PERIOD_NS = 40;
	localparam int LOSS_TIME_NS  = 10000;
	localparam int LOSS_CYCLES   =
		(LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Register map
	localparam logic [7:0] CTRL_ADDR    = 8'h00;
	localparam logic [7:0] STATUS_ADDR  = 8'h04;
	localparam logic [7:0] ERRORS_ADDR  = 8'h08;
	localparam logic [7:0] MEASURE_ADDR = 8'h0C;
	localparam logic [1:0] CTRL_RESET   = 2'h1;
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_FORCE  = 1;
	localparam int ERR_ACTIVE  = 0;
	localparam int ERR_HBLANK  = 1;
	localparam int ERR_HTOTAL  = 2;
	localparam int ERR_LINES   = 3;
	localparam int ERR_VBLANK  = 4;
	localparam int ERR_VTOTAL  = 5;
	localparam int ERR_W       = 6;

	// ==========================================================
	// Strap bit positions
	localparam int STRAP_DEPTH = 0;
	localparam int STRAP_JEIDA = 1;
	localparam int STRAP_DIM   = 2;
	localparam int STRAP_NOSIG = 3;

	typedef enum logic [1:0] {
		MODE_FALLBACK = 2'b01,
		MODE_LIVE     = 2'b10
	} mode_t;

endpackage

/* video_source_model.sv */
// Behavioural DE-only video source driving the four link inputs
`timescale 1ns/1ns
`default_nettype none
module video_source_model (
	// Link pins
	output logic [3:0]       clock_pos,
	output logic             de,
	output logic [3:0][23:0] main,
	output logic [3:0][5:0]  pair_e
);
	logic [23:0] main_val;
	logic [5:0]  e_val;
	logic        ten;
	logic [29:0] noise;

	// ==========================================================
	// Pins at rest
	initial begin
		clock_pos = 4'h0;
		de = 1'b0;
		main = '0;
		pair_e = '0;
		main_val = 24'hA53C0F;
		e_val = 6'h27;
		ten = 1'b1;
		noise = 30'h1;
	end

	// ==========================================================
	// One link clock; data moves on the falling edge
	// Period stretched so the slow sampling clock can follow it
	task automatic tick(input logic en);
		#160 clock_pos = 4'hF;
		#160 clock_pos = 4'h0;
		de = en;
		noise = {noise[28:0], ~noise[29]};
		for (int k = 0; k < 4; k++) begin
			main[k] = en ? main_val : noise[23:0];
			// Unused pair E toggles, so ignoring it is really tested
			pair_e[k] = (en && ten) ? e_val : noise[29:24];
		end
	endtask

	// ==========================================================
	// Gap then lines; clock stands still between calls
	// Short frames keep the run brief; rates follow the link period
	task automatic run(input int gap, input int n, input int act,
		input int blank);
		// Keeps link edges away from reference clock edges
		#((93 - $time % 40) % 40);
		repeat (gap) tick(1'b0);
		repeat (n) begin
			repeat (act) tick(1'b1);
			repeat (blank) tick(1'b0);
		end
	endtask
endmodule
`default_nettype wire
